// ### logic/sarseq_map.vh
`ifndef SARSEQ_MAP_VH
`define SARSEQ_MAP_VH
// ---------------------------------------------------------------
// Control byte fields
// ---------------------------------------------------------------
`define SARSEQ_PWR_HI       7
`define SARSEQ_PWR_LO       6
`define SARSEQ_ACQ_BIT      5
`define SARSEQ_SGL_BIT      4
`define SARSEQ_POL_BIT      3
`define SARSEQ_CH_HI        2
`define SARSEQ_CH_LO        0
// ---------------------------------------------------------------
// Power / clock mode codes
// ---------------------------------------------------------------
`define SARSEQ_PWR_INTCLK   2'h2
`define SARSEQ_PWR_EXTCLK   2'h3
// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define SARSEQ_CTRL_RESET   8'hc0
`define SARSEQ_ACQ_EDGES    4'h4
`define SARSEQ_CONV_CYCLES  4'hd
// Internal oscillator: about 1 us to hold, in ns, and system clock period in ns
`define SARSEQ_OSC_ACQ_NS   1000
`define SARSEQ_CLK_NS       8
// Oscillator half period in clocks: 13 cycles take about 3.5 us
`define SARSEQ_OSC_DIV      8'h11
`endif

// ### logic/sarseq_top.v
`timescale 1ns/1ps
`include "sarseq_map.vh"

module sarseq_top (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Parallel bus
  input  wire        i_cs_n,
  input  wire        i_wr_n,
  input  wire        i_rd_n,
  input  wire        i_high_byte_select,
  input  wire [7:0]  i_data,
  output reg  [7:0]  o_data,
  output wire        o_data_oe,
  output reg         o_done_n,
  // External converter clock pin
  input  wire        i_conv_clk,
  // Comparator from analog front end
  input  wire        i_cmp,
  // Analog switch controls
  output reg         o_track,
  output reg         o_hold_capacitor_neg,
  output reg  [2:0]  o_pos_channel,
  output reg  [2:0]  o_neg_channel,
  output reg         o_neg_common_return,
  output reg  [9:0]  o_dac,
  // Decoded configuration and busy status
  output reg  [1:0]  o_power_clock_select,
  output reg         o_polarity_select,
  output reg         o_single_or_paired,
  output reg         o_busy
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ACQ  = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  reg  [1:0] state;
  reg  [7:0] ctrl;
  reg        wr_q;
  reg        rd_q;
  reg        cclk_q;
  reg        osc;
  reg  [7:0] osc_cnt;
  reg        sel_clk_q;
  reg  [3:0] cnt;
  reg  [9:0] sar;
  reg  [9:0] bitmask;
  reg  [9:0] result;

  wire wr_rise  = ~i_cs_n & i_wr_n & ~wr_q;
  wire rd_fall  = ~i_cs_n & ~i_rd_n & rd_q;
  wire acq_ext  = i_data[`SARSEQ_ACQ_BIT];
  wire int_clk  = ctrl[`SARSEQ_PWR_HI:`SARSEQ_PWR_LO] == `SARSEQ_PWR_INTCLK;
  wire sel_clk  = int_clk ? osc : cclk_q;
  wire clk_fall = sel_clk_q & ~sel_clk;
  wire [1:0] new_pwr = i_data[`SARSEQ_PWR_HI:`SARSEQ_PWR_LO];

  assign o_data_oe = ~i_cs_n & ~i_rd_n;

  // ---------------------------------------------------------------
  // Converter clock source
  // ---------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc       <= 1'b0;
      osc_cnt   <= 8'h00;
      cclk_q    <= 1'b0;
      sel_clk_q <= 1'b0;
    end else begin
      cclk_q    <= i_conv_clk;
      sel_clk_q <= sel_clk;
      // Oscillator period chosen so four falls take about 1 us
      if (osc_cnt == `SARSEQ_OSC_DIV - 8'h01) begin
        osc_cnt <= 8'h00;
        osc     <= ~osc;
      end else begin
        osc_cnt <= osc_cnt + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state                <= ST_IDLE;
      ctrl                 <= `SARSEQ_CTRL_RESET;
      wr_q                 <= 1'b1;
      rd_q                 <= 1'b1;
      cnt                  <= 4'h0;
      sar                  <= 10'h000;
      bitmask              <= 10'h000;
      result               <= 10'h000;
      o_done_n             <= 1'b1;
      o_track              <= 1'b0;
      o_hold_capacitor_neg <= 1'b0;
      o_dac                <= 10'h000;
      o_busy               <= 1'b0;
    end else begin
      wr_q <= i_wr_n;
      rd_q <= i_rd_n;
      if (rd_fall) begin
        o_done_n <= 1'b1;
      end
      if (wr_rise) begin
        o_done_n <= 1'b1;
        // Power bits: keep last clock mode on power-down codes
        if (new_pwr[1]) begin
          ctrl[`SARSEQ_PWR_HI:`SARSEQ_PWR_LO] <= new_pwr;
        end
        ctrl[`SARSEQ_ACQ_BIT:0] <= i_data[`SARSEQ_ACQ_BIT:0];
        if (state == ST_ACQ && ctrl[`SARSEQ_ACQ_BIT] && !acq_ext) begin
          // Closing write: hold and convert
          state                <= ST_CONV;
          o_track              <= 1'b0;
          o_hold_capacitor_neg <= 1'b1;
          cnt                  <= 4'h0;
          sar                  <= 10'h000;
          bitmask              <= 10'h200;
          o_dac                <= 10'h200;
          o_busy               <= 1'b1;
        end else begin
          // Open acquisition; aborts any conversion
          state                <= ST_ACQ;
          o_track              <= 1'b1;
          o_hold_capacitor_neg <= 1'b0;
          cnt                  <= 4'h0;
          o_busy               <= 1'b1;
        end
      end else begin
        case (state)
          ST_ACQ: begin
            if (!ctrl[`SARSEQ_ACQ_BIT] && clk_fall) begin
              if (cnt == `SARSEQ_ACQ_EDGES - 4'h1) begin
                state                <= ST_CONV;
                o_track              <= 1'b0;
                o_hold_capacitor_neg <= 1'b1;
                cnt                  <= 4'h0;
                sar                  <= 10'h000;
                bitmask              <= 10'h200;
                o_dac                <= 10'h200;
              end else begin
                cnt <= cnt + 4'h1;
              end
            end
          end
          ST_CONV: begin
            if (clk_fall) begin
              cnt <= cnt + 4'h1;
              if (bitmask != 10'h000) begin
                if (i_cmp) begin
                  sar <= sar | bitmask;
                end
                bitmask <= bitmask >> 1;
                o_dac   <= (sar | (i_cmp ? bitmask : 10'h000))
                           | (bitmask >> 1);
              end
              if (cnt == `SARSEQ_CONV_CYCLES - 4'h1) begin
                state                <= ST_IDLE;
                result               <= sar;
                o_done_n             <= 1'b0;
                o_busy               <= 1'b0;
                o_hold_capacitor_neg <= 1'b0;
              end
            end
          end
          ST_IDLE: begin
            o_busy <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Input routing and bus output
  // ---------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data               <= 8'h00;
      o_pos_channel        <= 3'h0;
      o_neg_channel        <= 3'h0;
      o_neg_common_return  <= 1'b1;
      o_power_clock_select <= 2'h3;
      o_polarity_select    <= 1'b0;
      o_single_or_paired   <= 1'b0;
    end else begin
      o_data <= i_high_byte_select ? {6'h00, result[9:8]}
                                   : result[7:0];
      o_power_clock_select <= ctrl[`SARSEQ_PWR_HI:`SARSEQ_PWR_LO];
      o_polarity_select    <= ctrl[`SARSEQ_POL_BIT];
      o_single_or_paired   <= ctrl[`SARSEQ_SGL_BIT];
      if (ctrl[`SARSEQ_SGL_BIT]) begin
        o_pos_channel       <= ctrl[`SARSEQ_CH_HI:`SARSEQ_CH_LO];
        o_neg_channel       <= 3'h0;
        o_neg_common_return <= 1'b1;
      end else begin
        // Pair: address LSB picks which of the pair is positive
        o_pos_channel       <= ctrl[`SARSEQ_CH_HI:`SARSEQ_CH_LO];
        o_neg_channel       <= ctrl[`SARSEQ_CH_HI:`SARSEQ_CH_LO] ^ 3'h1;
        o_neg_common_return <= 1'b0;
      end
    end
  end

endmodule // sarseq_top

// ### testbench/sarseq_top_assertions.sv
`timescale 1ns/1ps
module sarseq_checker (
  // Watched ports
  input wire       i_clk,
  input wire       i_rst,
  input wire       i_cs_n,
  input wire       i_wr_n,
  input wire       i_rd_n,
  input wire       i_high_byte_select,
  input wire [7:0] i_data,
  input wire [7:0] o_data,
  input wire       o_data_oe,
  input wire       o_done_n,
  input wire       o_track,
  input wire       o_hold_capacitor_neg,
  input wire       o_neg_common_return,
  input wire       o_single_or_paired,
  input wire       o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr;
    !i_cs_n && i_wr_n && !$past(i_wr_n);
  endsequence
  sequence s_rd;
    !i_cs_n && $fell(i_rd_n);
  endsequence
  a_track_open: assert property (
    s_wr ##0 i_data[5] |-> ##[1:2] o_track && o_busy) else $error("no track");
  a_write_clear: assert property (
    s_wr |-> ##[1:2] o_done_n) else $error("done kept on write");
  a_read_clear: assert property (
    s_rd |-> ##[1:2] o_done_n) else $error("done kept on read");
  a_bus_drive: assert property (
    o_data_oe == (!i_cs_n && !i_rd_n)) else $error("bus enable wrong");
  a_high_pair: assert property (
    $past(i_high_byte_select) |-> o_data[7:2] == 6'h0) else $error("high byte");
  a_hold_excl: assert property (
    !(o_track && o_hold_capacitor_neg)) else $error("track during hold");
  a_done_idle: assert property (
    $fell(o_done_n) |-> !o_busy && !o_track) else $error("done while busy");
  a_single_ret: assert property (
    o_busy && o_single_or_paired |-> o_neg_common_return) else $error("return");
endmodule // sarseq_checker
bind sarseq_top sarseq_checker sarseq_checker_i (.*);

// ### testbench/sarseq_host.sv
`timescale 1ns/1ps
module sarseq_host (
  // Bus to device
  input  wire        i_clk,
  input  wire  [7:0] i_bus,
  output logic       o_cs_n,
  output logic       o_wr_n,
  output logic       o_rd_n,
  output logic       o_hbs,
  output logic [7:0] o_data
);
  initial {o_cs_n, o_wr_n, o_rd_n, o_hbs, o_data} = 12'he00;
  // Released bus shows the inverse of the last byte
  task automatic wr(input logic [7:0] b);
    @(posedge i_clk) {o_cs_n, o_wr_n, o_data} <= {2'h0, b};
    @(posedge i_clk) o_wr_n <= 1'b1;
    @(posedge i_clk) {o_cs_n, o_data} <= {1'b1, ~b};
  endtask
  task automatic rd(input logic h, output logic [7:0] v);
    @(posedge i_clk) {o_cs_n, o_hbs} <= {1'b0, h};
    @(posedge i_clk) o_rd_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    v = i_bus;
    {o_cs_n, o_rd_n} <= 2'h3;
  endtask
endmodule // sarseq_host

// ### testbench/sarseq_top_tb.sv
`timescale 1ns/1ps
`include "sarseq_map.vh"
module sarseq_top_tb;
  logic       i_clk = 0, i_rst = 1, i_conv_clk = 0, i_cmp = 0;
  logic       i_cs_n, i_wr_n, i_rd_n, i_high_byte_select, o_data_oe;
  logic       o_done_n, o_track, o_hold_capacitor_neg, o_busy;
  logic       o_neg_common_return, o_polarity_select, o_single_or_paired;
  logic [7:0] i_data, o_data, hi, lo;
  logic [2:0] o_pos_channel, o_neg_channel;
  logic [9:0] o_dac;
  logic [1:0] o_power_clock_select;
  int         n_errors = 0, samples_checked = 0, k, nf, m, cc = 0;
  // Control byte, comparator level, expected result
  logic [18:0] rows [4] = '{{8'hd9, 1'b1, 10'h3ff}, {8'hc6, 1'b0, 10'h0},
                            {8'hd3, 1'b1, 10'h3ff}, {8'hcc, 1'b0, 10'h0}};
  sarseq_top sarseq_top_i (.*);
  sarseq_host sarseq_host_i (.i_clk(i_clk), .i_bus(o_data), .o_cs_n(i_cs_n),
    .o_wr_n(i_wr_n), .o_rd_n(i_rd_n), .o_hbs(i_high_byte_select),
    .o_data(i_data));
  initial forever #4 i_clk = ~i_clk;
  // Converter clock: half period of 5 system clocks, launched on the edge
  always @(posedge i_clk) begin
    cc <= (cc == 4) ? 0 : cc + 1;
    if (cc == 4) begin
      i_conv_clk <= ~i_conv_clk;
    end
  end
  always @(negedge i_conv_clk) nf++;
  task automatic check(string nm, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Write just after a converter clock fall, then restart the fall count
  task automatic w(logic [7:0] b);
    @(negedge i_conv_clk);
    sarseq_host_i.wr(b);
    nf = 0;
  endtask
  // Wait for track low (d=0) or done low (d=1)
  task automatic wt(bit d);
    @(posedge i_clk);
    for (k = 0; k < 2000; k++) begin
      @(posedge i_clk);
      if ((d ? o_done_n : o_track) === 1'b0) return;
    end
    n_errors++;
    finish_test;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check("reset", {o_done_n, o_track, o_neg_common_return}, 5);
    check("clock mode", o_power_clock_select, 3);
    foreach (rows[i]) begin
      i_cmp <= rows[i][10];
      w(rows[i][18:11]);
      wt(0);
      check("acq falls", nf, 4);
      check("hold", o_hold_capacitor_neg, 1);
      check("first trial", o_dac, 10'h200);
      check("channel", o_pos_channel, rows[i][13:11]);
      check("neg side", {o_neg_common_return, o_neg_channel},
            rows[i][15] ? 4'h8 : {1'b0, rows[i][13:11] ^ 3'h1});
      check("mode", {o_single_or_paired, o_polarity_select}, rows[i][15:14]);
      m = nf;
      wt(1);
      check("conv falls", nf - m, 13);
      check("last trial", o_dac, rows[i][9:0]);
      sarseq_host_i.rd(1, hi);
      sarseq_host_i.rd(0, lo);
      check("result", {hi, lo}, rows[i][9:0]);
      check("done read", o_done_n, 1);
    end
    i_cmp <= 1'b1;
    w(8'hf9);
    repeat (40) @(posedge i_clk);
    check("ext track", o_track, 1);
    w(8'hd9);
    repeat (2) @(posedge i_clk);
    check("ext hold", {o_track, o_hold_capacitor_neg}, 1);
    wt(1);
    check("ext falls", nf, 13);
    i_cmp <= 1'b0;
    w(8'hd9);
    wt(0);
    w(8'hd9);
    repeat (2) @(posedge i_clk);
    check("abort", {o_track, o_done_n, o_hold_capacitor_neg}, 6);
    sarseq_host_i.rd(0, lo);
    check("old result", lo, 8'hff);
    wt(1);
    sarseq_host_i.rd(0, lo);
    check("new result", lo, 8'h00);
    w(8'h99);
    wt(0);
    check("osc acq", k * `SARSEQ_CLK_NS >= `SARSEQ_OSC_ACQ_NS * 3 / 4 &&
          k * `SARSEQ_CLK_NS <= `SARSEQ_OSC_ACQ_NS * 5 / 4, 1);
    check("clock mode int", o_power_clock_select, 2);
    wt(1);
    check("osc conv", k > 24 * `SARSEQ_OSC_DIV &&
          k < 28 * `SARSEQ_OSC_DIV, 1);
    finish_test;
  end
endmodule // sarseq_top_tb
